// ---- hdl/rwc_pkg.sv ----
package rwc_pkg;

   // register byte offsets on the axi4-lite bus
   localparam int          ADDR_W     = 4;
   localparam logic [3:0]  OFS_CTRL   = 4'h0;  // run, wait, pin enables
   localparam logic [3:0]  OFS_CORR   = 4'h4;  // watch_correction_reg
   localparam logic [3:0]  OFS_SECS   = 4'h8;  // seconds counter
   localparam logic [3:0]  OFS_SUBCNT = 4'hc;  // sub-second counter, read only

   // reset values
   localparam logic [3:0]  CTRL_RST   = 4'h0;
   localparam logic [7:0]  CORR_RST   = 8'h00;
   localparam logic [31:0] SECS_RST   = 32'h0000_0000;
   localparam logic [15:0] SUB_RST    = 16'h0000;

   // field widths inside the data word
   localparam int          CTRL_W     = 4;
   localparam int          CORR_W     = 8;

   // sub-second counting
   localparam logic [15:0] SUB_TERMINAL = 16'h7fff;  // uncorrected last count
   localparam logic [15:0] SUB_HALF     = 16'h4000;  // 1 hz pin high below this
   localparam logic [15:0] ADJ_OFFSET   = 16'h0002;  // adjust = 2*mag - 2

   // last index of the correction interval (20 or 60 seconds)
   localparam logic [5:0]  INTERVAL_SHORT_LAST = 6'h13;
   localparam logic [5:0]  INTERVAL_LONG_LAST  = 6'h3b;

   // axi response codes
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // control register layout, msb first
   typedef struct packed {
      logic one_hz_out_en;     // bit 3
      logic sub_out_en;        // bit 2
      logic counter_wait;      // bit 1
      logic clock_run_enable;  // bit 0
   } rwc_ctrl_t;

   // watch_correction_reg layout, msb first
   typedef struct packed {
      logic       correction_interval_sel;  // bit 7: 0 = 20 s, 1 = 60 s
      logic       correction_direction;     // bit 6: 0 = longer, 1 = shorter
      logic [5:0] magnitude;                // bits 5..0
   } rwc_corr_t;

   // one register write as handed from the bus slave
   typedef struct packed {
      logic        en;
      logic [3:0]  addr;
      logic [31:0] data;
      logic [3:0]  strb;
   } rwc_reg_wr_t;

   // true for an offset that holds a register
   function automatic logic reg_mapped(input logic [3:0] addr);
      reg_mapped = (addr == OFS_CTRL) || (addr == OFS_CORR) ||
                   (addr == OFS_SECS) || (addr == OFS_SUBCNT);
   endfunction

endpackage

// ---- hdl/rwc_sync_edge.sv ----
`timescale 1ns/100ps
// two-flop synchroniser with a rising edge pulse taken behind it
module rwc_sync_edge (
   // clock and reset
   input  wire logic core_clk,
   input  wire logic reset_n,
   // asynchronous pin in
   input  wire logic pin_in,
   // synchronised level and edge pulse
   output logic      level_out,
   output logic      rise_out
);

   logic meta_ff;   // first stage, read only by the second
   logic sync_ff;   // second stage, safe to use
   logic prev_ff;   // delayed copy for edge detection

   // synchroniser chain
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
         prev_ff <= 1'b0;
      end else begin
         meta_ff <= pin_in;
         sync_ff <= meta_ff;
         prev_ff <= sync_ff;
      end
   end

   // edge pulse is registered so it is one clean cycle
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rise_out <= 1'b0;
      end else begin
         rise_out <= sync_ff & ~prev_ff;
      end
   end

   assign level_out = sync_ff;

endmodule

// ---- hdl/rwc_axil_slave.sv ----
`timescale 1ns/100ps
// axi4-lite slave: one write and one read in flight, fixed latency
module rwc_axil_slave (
   // clock and reset
   input  wire logic                      core_clk,
   input  wire logic                      reset_n,
   // write address and data channels
   input  wire logic [rwc_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   // write response channel
   output logic [1:0]                     s_axi_bresp,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   // read channels
   input  wire logic [rwc_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   output logic [31:0]                    s_axi_rdata,
   output logic [1:0]                     s_axi_rresp,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready,
   // register side
   output rwc_pkg::rwc_reg_wr_t           reg_wr,
   input  wire logic [31:0]               rd_data
);

   logic                      aw_held_ff;  // address captured, waiting
   logic                      w_held_ff;   // data captured, waiting
   logic [rwc_pkg::ADDR_W-1:0] aw_addr_ff;
   logic [31:0]               w_data_ff;
   logic [3:0]                w_strb_ff;
   logic                      aw_take;
   logic                      w_take;
   logic                      ar_take;

   // ready only while the holding slot is free
   assign s_axi_awready = ~aw_held_ff & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_held_ff & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;
   assign aw_take       = s_axi_awvalid & s_axi_awready;
   assign w_take        = s_axi_wvalid & s_axi_wready;
   assign ar_take       = s_axi_arvalid & s_axi_arready;

   // capture address and data in either order
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         aw_held_ff <= 1'b0;
         w_held_ff  <= 1'b0;
         aw_addr_ff <= '0;
         w_data_ff  <= 32'h0000_0000;
         w_strb_ff  <= 4'h0;
      end else if (aw_held_ff && w_held_ff) begin
         aw_held_ff <= 1'b0;
         w_held_ff  <= 1'b0;
      end else begin
         if (aw_take) begin
            aw_held_ff <= 1'b1;
            aw_addr_ff <= s_axi_awaddr;
         end
         if (w_take) begin
            w_held_ff <= 1'b1;
            w_data_ff <= s_axi_wdata;
            w_strb_ff <= s_axi_wstrb;
         end
      end
   end

   // write strobe and response once both halves are in
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_wr       <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= rwc_pkg::RESP_OKAY;
      end else begin
         reg_wr.en <= 1'b0;
         if (aw_held_ff && w_held_ff) begin
            // unmapped offsets are ignored and answered with an error
            reg_wr.en    <= rwc_pkg::reg_mapped(aw_addr_ff);
            reg_wr.addr  <= aw_addr_ff;
            reg_wr.data  <= w_data_ff;
            reg_wr.strb  <= w_strb_ff;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= rwc_pkg::reg_mapped(aw_addr_ff) ?
                            rwc_pkg::RESP_OKAY : rwc_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // read answer one cycle after the address is taken
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= rwc_pkg::RESP_OKAY;
      end else if (ar_take) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_data;
         s_axi_rresp  <= rwc_pkg::reg_mapped(s_axi_araddr) ?
                         rwc_pkg::RESP_OKAY : rwc_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule

// ---- hdl/rwc_watch.sv ----
`timescale 1ns/100ps

// Overview of operation
// - sub-second counter wraps after 7fff uncorrected
// - seconds advance on wrap when run, not wait
// - direction zero lengthens, one shortens corrected second
// - magnitude bits five to one zero: no correction
// - interval zero corrects one second in twenty
// - interval one corrects one second in sixty
// - uncorrected seconds all have identical length
// - tick every second while run is set, corrected seconds included
// - raw oscillator and 1 hz tick on pins
// - only long-term elapsed time is corrected
module rwc_watch (
   // clock and reset
   input  wire logic                      core_clk,
   input  wire logic                      reset_n,
   // subsystem oscillator pin
   input  wire logic                      sub_osc_clock,
   // axi4-lite write channels
   input  wire logic [rwc_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   output logic [1:0]                     s_axi_bresp,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   // axi4-lite read channels
   input  wire logic [rwc_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   output logic [31:0]                    s_axi_rdata,
   output logic [1:0]                     s_axi_rresp,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready,
   // clock outputs and second tick
   output logic                           sub_clock_out,
   output logic                           one_hz_out,
   output logic                           one_sec_tick
);

   // register bus
   rwc_pkg::rwc_reg_wr_t reg_wr;        // write strobe from the slave
   logic [31:0]          rd_data;       // read mux toward the slave

   // software registers
   rwc_pkg::rwc_ctrl_t   ctrl_ff;       // run, wait and pin enables
   rwc_pkg::rwc_corr_t   corr_ff;       // watch_correction_reg
   logic [31:0]          secs_ff;       // seconds counter

   // counting state
   logic [15:0]          sub_cnt_ff;    // sub-second counter
   logic [15:0]          nxt_sub_cnt;
   logic [5:0]           interval_ff;   // seconds within the interval
   logic [5:0]           nxt_interval;
   logic                 wrap;          // counter returns to zero now

   // correction terms
   logic                 corr_on;       // magnitude bits five to one not all zero
   logic [15:0]          adj_cnt;       // counts added or removed
   logic [5:0]           interval_last; // last index of the interval
   logic                 corr_second;   // current second carries the adjust
   logic [15:0]          terminal;      // last count of this second

   // synchronised oscillator
   logic                 osc_level;     // pin level after two flops
   logic                 counter_clock; // one-cycle enable per rising osc edge

   // merges a write into a register under the byte strobes
   function automatic logic [31:0] apply_strb(input logic [31:0] old_val,
                                              input logic [31:0] new_val,
                                              input logic [3:0]  strb);
      logic [31:0] res;
      res = old_val;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = new_val[b*8 +: 8];
         end
      end
      apply_strb = res;
   endfunction

   // true when a write strobe targets the given offset
   function automatic logic wr_hit(input rwc_pkg::rwc_reg_wr_t wr,
                                   input logic [3:0]           ofs);
      wr_hit = wr.en && (wr.addr == ofs);
   endfunction

   // bus slave
   rwc_axil_slave u_slave (
      .core_clk      (core_clk),
      .reset_n       (reset_n),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .reg_wr        (reg_wr),
      .rd_data       (rd_data)
   );

   // oscillator pin into the core clock domain
   rwc_sync_edge u_osc_sync (
      .core_clk  (core_clk),
      .reset_n   (reset_n),
      .pin_in    (sub_osc_clock),
      .level_out (osc_level),
      .rise_out  (counter_clock)
   );

   // control register, low byte only
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_ff <= rwc_pkg::CTRL_RST;
      end else if (wr_hit(reg_wr, rwc_pkg::OFS_CTRL) && reg_wr.strb[0]) begin
         ctrl_ff <= reg_wr.data[rwc_pkg::CTRL_W-1:0];
      end
   end

   // correction register, low byte only; takes effect at the next compare
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         corr_ff <= rwc_pkg::CORR_RST;
      end else if (wr_hit(reg_wr, rwc_pkg::OFS_CORR) && reg_wr.strb[0]) begin
         corr_ff <= reg_wr.data[rwc_pkg::CORR_W-1:0];
      end
   end

   // correction decode
   always_comb begin
      // only bits five to one decide whether correction is on
      corr_on       = |corr_ff.magnitude[5:1];
      // twice the magnitude less two: 2 .. 124 counts
      adj_cnt       = {9'h000, corr_ff.magnitude, 1'b0} - rwc_pkg::ADJ_OFFSET;
      // interval length chosen by the interval bit
      if (corr_ff.correction_interval_sel) begin
         interval_last = rwc_pkg::INTERVAL_LONG_LAST;
      end else begin
         interval_last = rwc_pkg::INTERVAL_SHORT_LAST;
      end
      // one second per interval carries the adjustment
      corr_second   = corr_on && (interval_ff == interval_last);
      // terminal count of the current second
      if (!corr_second) begin
         terminal = rwc_pkg::SUB_TERMINAL;
      end else if (corr_ff.correction_direction) begin
         terminal = rwc_pkg::SUB_TERMINAL - adj_cnt;
      end else begin
         terminal = rwc_pkg::SUB_TERMINAL + adj_cnt;
      end
   end

   // next sub-second count and wrap detection
   always_comb begin
      wrap        = 1'b0;
      nxt_sub_cnt = sub_cnt_ff;
      if (counter_clock) begin
         // >= guards a shortened terminal written mid-second
         if (sub_cnt_ff >= terminal) begin
            wrap        = 1'b1;
            nxt_sub_cnt = rwc_pkg::SUB_RST;
         end else begin
            nxt_sub_cnt = sub_cnt_ff + 16'h0001;
         end
      end
   end

   // sub-second counter: one step per rising oscillator edge
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         sub_cnt_ff <= rwc_pkg::SUB_RST;
      end else begin
         sub_cnt_ff <= nxt_sub_cnt;
      end
   end

   // next position within the correction interval
   always_comb begin
      nxt_interval = interval_ff;
      if (wrap) begin
         // >= recovers when the interval shrinks from 60 to 20
         if (interval_ff >= interval_last) begin
            nxt_interval = 6'h00;
         end else begin
            nxt_interval = interval_ff + 6'h01;
         end
      end
   end

   // interval counter counts every wrapped second
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         interval_ff <= 6'h00;
      end else begin
         interval_ff <= nxt_interval;
      end
   end

   // seconds counter: software load wins over the wrap increment
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         secs_ff <= rwc_pkg::SECS_RST;
      end else if (wr_hit(reg_wr, rwc_pkg::OFS_SECS)) begin
         secs_ff <= apply_strb(secs_ff, reg_wr.data, reg_wr.strb);
      end else if (wrap && ctrl_ff.clock_run_enable && !ctrl_ff.counter_wait) begin
         secs_ff <= secs_ff + 32'h0000_0001;
      end
   end

   // one-cycle tick on every second while running, corrected or not
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         one_sec_tick <= 1'b0;
      end else begin
         one_sec_tick <= wrap && ctrl_ff.clock_run_enable;
      end
   end

   // 1 hz pin: high for the first half of each counted second
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         one_hz_out <= 1'b0;
      end else begin
         one_hz_out <= ctrl_ff.one_hz_out_en &&
                       (nxt_sub_cnt < rwc_pkg::SUB_HALF);
      end
   end

   // raw oscillator copy, delayed by the synchroniser
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         sub_clock_out <= 1'b0;
      end else begin
         sub_clock_out <= ctrl_ff.sub_out_en && osc_level;
      end
   end

   // read mux; unmapped and reserved bits read as zero
   always_comb begin
      case (s_axi_araddr)
         rwc_pkg::OFS_CTRL: begin
            rd_data = {28'h0000000, ctrl_ff};
         end
         rwc_pkg::OFS_CORR: begin
            rd_data = {24'h000000, corr_ff};
         end
         rwc_pkg::OFS_SECS: begin
            rd_data = secs_ff;
         end
         rwc_pkg::OFS_SUBCNT: begin
            rd_data = {16'h0000, sub_cnt_ff};
         end
         default: begin
            rd_data = 32'h0000_0000;
         end
      endcase
   end

endmodule

// ---- verif/rwc_watch_assertions.sv ----
`timescale 1ns/100ps
// watches the bus handshakes, the raw clock output pin and the second tick
module rwc_watch_assertions (
   // clock and reset
   input wire logic        core_clk,
   input wire logic        reset_n,
   // oscillator and its outputs
   input wire logic        sub_osc_clock,
   input wire logic        sub_clock_out,
   input wire logic        one_sec_tick,
   // write channels
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   // read channels
   input wire logic [3:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   logic [3:0] ar_ff;     // address of the last read taken
   logic [3:0] since_ff;  // cycles since the oscillator pin was high, saturating

   // remember the read address so the answer can be judged
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) ar_ff <= 4'h0;
      else if (s_axi_arvalid && s_axi_arready) ar_ff <= s_axi_araddr;
   end

   // age of the last high level on the oscillator pin
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) since_ff <= 4'hf;
      else if (sub_osc_clock) since_ff <= 4'h0;
      else if (since_ff != 4'hf) since_ff <= since_ff + 4'h1;
   end

   aw_blocked_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while a response is pending");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response not held");
   b_latency_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write response not two edges later");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read answer not held");
   ar_blocked_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while an answer is pending");
   r_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer not on the next edge");
   r_decode_a: assert property (s_axi_rvalid |-> (ar_ff[1:0] == 2'h0) ?
      (s_axi_rresp == rwc_pkg::RESP_OKAY) :
      (s_axi_rresp == rwc_pkg::RESP_SLVERR && s_axi_rdata == 32'h0))
      else $error("read response does not match address decode");
   tick_pulse_a: assert property (one_sec_tick |=> !one_sec_tick)
      else $error("second tick longer than one cycle");
   tick_cause_a: assert property (one_sec_tick |-> since_ff <= 4'h8)
      else $error("second tick without a recent oscillator edge");
   clk_out_cause_a: assert property ($rose(sub_clock_out) |-> since_ff <= 4'h6)
      else $error("clock output rose without the oscillator pin");

   write_done_c: cover property (s_axi_bvalid && s_axi_bready);
   read_err_c: cover property (s_axi_rvalid && s_axi_rresp == rwc_pkg::RESP_SLVERR);
   tick_c: cover property (one_sec_tick);
   clk_out_c: cover property ($rose(sub_clock_out));
endmodule

// ---- verif/rwc_watch_tb.sv ----
`timescale 1ns/100ps
// drives the watch block over its register bus and its oscillator pin
module rwc_watch_tb;
   logic        core_clk, reset_n, sub_osc_clock;
   logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, sub_clock_out, one_hz_out, one_sec_tick;
   logic        osc_run;      // lets the oscillator pin toggle
   logic        sub_seen;     // clock output was seen high
   int          osc_rises;    // rising edges put on the oscillator pin
   int          n;            // bounded wait counter
   int          n_errors, checks_done;

   rwc_watch rwc_watch_inst (.*);

   // 100 mhz core clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // oscillator at half the core rate, fastest the synchroniser can follow
   always @(posedge core_clk) begin
      if (osc_run) begin
         sub_osc_clock <= ~sub_osc_clock;
         if (!sub_osc_clock) osc_rises <= osc_rises + 1;
      end
   end

   // note any high level on the raw clock output
   always @(negedge core_clk) begin
      if (sub_clock_out === 1'b1) sub_seen = 1'b1;
   end

   // compares one value
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask

   // compares a count against a window that allows for the pin synchroniser
   task automatic chk_rng(input string what, input int lo, input int hi, input int got);
      checks_done++;
      if (got < lo || got > hi) begin
         n_errors++;
         $display("FAIL %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask

   // one bus write; halves released as taken, response awaited
   task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                            input logic [1:0] er);
      logic       aw_hs, w_hs, got;
      logic [1:0] resp;
      got = 1'b0;
      n = 0;
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!got && n < 100) begin
         @(negedge core_clk);
         aw_hs = (s_axi_awvalid & s_axi_awready) === 1'b1;
         w_hs = (s_axi_wvalid & s_axi_wready) === 1'b1;
         got = s_axi_bvalid === 1'b1;
         resp = s_axi_bresp;
         @(posedge core_clk);
         if (aw_hs) s_axi_awvalid <= 1'b0;
         if (w_hs) s_axi_wvalid <= 1'b0;
         if (got) s_axi_bready <= 1'b0;
         n++;
      end
      chk($sformatf("bvalid %h", a), 32'h1, {31'h0, got});
      chk($sformatf("bresp %h", a), {30'h0, er}, {30'h0, resp});
   endtask

   // one bus read; data and response taken at the edge with rvalid
   task automatic axi_read(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic        ar_hs, got;
      logic [31:0] data;
      logic [1:0]  resp;
      got = 1'b0;
      n = 0;
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!got && n < 100) begin
         @(negedge core_clk);
         ar_hs = (s_axi_arvalid & s_axi_arready) === 1'b1;
         got = s_axi_rvalid === 1'b1;
         data = s_axi_rdata;
         resp = s_axi_rresp;
         @(posedge core_clk);
         if (ar_hs) s_axi_arvalid <= 1'b0;
         if (got) s_axi_rready <= 1'b0;
         n++;
      end
      chk($sformatf("rdata %h", a), ed, data);
      chk($sformatf("rresp %h", a), {30'h0, er}, {30'h0, resp});
   endtask

   // prints the counts and the verdict, then stops
   task automatic give_verdict();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // ends a hang; the tests need about 70000 cycles
   initial begin
      repeat (90000) @(posedge core_clk);
      n_errors++;
      give_verdict();
   end

   // main sequence
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      sub_osc_clock = 1'b0;
      osc_run = 1'b0;
      sub_seen = 1'b0;
      osc_rises = 0;
      n_errors = 0;
      checks_done = 0;
      reset_n = 1'b0;
      repeat (8) @(posedge core_clk);
      reset_n <= 1'b1;
      // reset values of every register and pin
      for (int i = 0; i < 4; i++) axi_read(4'(4 * i), 32'h0, rwc_pkg::RESP_OKAY);
      chk("pins", 32'h0, {29'h0, sub_clock_out, one_hz_out, one_sec_tick});
      $display("test reset done");
      // correction fields, byte lanes, read-only and unmapped places
      axi_write(rwc_pkg::OFS_CORR, 32'h42, 4'h1, rwc_pkg::RESP_OKAY);
      axi_read(rwc_pkg::OFS_CORR, 32'h42, rwc_pkg::RESP_OKAY);
      axi_write(rwc_pkg::OFS_CORR, 32'h3f, 4'he, rwc_pkg::RESP_OKAY);
      axi_read(rwc_pkg::OFS_CORR, 32'h42, rwc_pkg::RESP_OKAY);
      axi_write(rwc_pkg::OFS_CTRL, 32'hfffffff2, 4'hf, rwc_pkg::RESP_OKAY);
      axi_read(rwc_pkg::OFS_CTRL, 32'h2, rwc_pkg::RESP_OKAY);
      axi_write(rwc_pkg::OFS_SECS, 32'haabbccdd, 4'h3, rwc_pkg::RESP_OKAY);
      axi_read(rwc_pkg::OFS_SECS, 32'h0000ccdd, rwc_pkg::RESP_OKAY);
      axi_write(rwc_pkg::OFS_SUBCNT, 32'h1234, 4'hf, rwc_pkg::RESP_OKAY);
      axi_read(rwc_pkg::OFS_SUBCNT, 32'h0, rwc_pkg::RESP_OKAY);
      for (int i = 0; i < 16; i++) begin
         if (i % 4 != 0) begin
            axi_write(4'(i), 32'h1, 4'hf, rwc_pkg::RESP_SLVERR);
            axi_read(4'(i), 32'h0, rwc_pkg::RESP_SLVERR);
         end
      end
      $display("test registers done");
      // one full second; the lengthened second is not due until the twentieth
      axi_write(rwc_pkg::OFS_SECS, 32'h5, 4'hf, rwc_pkg::RESP_OKAY);
      axi_write(rwc_pkg::OFS_CORR, 32'h3f, 4'h1, rwc_pkg::RESP_OKAY);
      axi_write(rwc_pkg::OFS_CTRL, 32'hd, 4'h1, rwc_pkg::RESP_OKAY);
      axi_read(rwc_pkg::OFS_CTRL, 32'hd, rwc_pkg::RESP_OKAY);
      chk("one hz before start", 32'h1, {31'h0, one_hz_out});
      chk("clock out before start", 32'h0, {31'h0, sub_seen});
      @(posedge core_clk);
      osc_run <= 1'b1;
      n = 0;
      while (one_hz_out !== 1'b0 && n < 40000) begin
         @(negedge core_clk);
         n++;
      end
      chk_rng("rises at one hz fall", 16384, 16387, osc_rises);
      while (one_sec_tick !== 1'b1 && n < 80000) begin
         @(negedge core_clk);
         n++;
      end
      chk_rng("rises at tick", 32768, 32771, osc_rises);
      @(posedge core_clk);
      osc_run <= 1'b0;
      axi_read(rwc_pkg::OFS_SECS, 32'h6, rwc_pkg::RESP_OKAY);
      chk("one hz restarts", 32'h1, {31'h0, one_hz_out});
      chk("clock out ran", 32'h1, {31'h0, sub_seen});
      $display("test second done");
      give_verdict();
   end
endmodule

bind rwc_watch rwc_watch_assertions rwc_watch_assertions_inst (.*);
